// [spi_position_command_port.v]
// spi slave command port of a sin/cos interpolator
// assumes sclk, mosi and slave select come from the host master asynchronously;
// position, capture, adc and fault values come from the interpolator on sys_clk
`timescale 1ns/100ps
`include "spi_position_command_port_defines.vh"
module spi_position_command_port (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        sclk,
    input  wire        mosi,
    input  wire        slave_select_n,
    output reg         miso,
    output reg         miso_oe,
    input  wire [9:0]  angle_in,
    input  wire        quad_outputs_enabled,
    input  wire        counter_step,
    input  wire        counter_dir_down,
    input  wire        capture_pulse,
    input  wire [13:0] capture_counter_in,
    input  wire [9:0]  capture_angle_in,
    input  wire [9:0]  sine_sample,
    input  wire [9:0]  cosine_sample,
    input  wire [7:0]  index_sample,
    input  wire [7:0]  fatal_fault_reg,
    input  wire        irq_request_in,
    input  wire        capture_irq_enable,
    input  wire        rollover_irq_enable,
    input  wire        restart_cmd,
    input  wire [7:0]  reg_read_data,
    output reg  [15:0] reg_addr,
    output reg  [7:0]  reg_wdata,
    output reg         reg_write,
    output reg         cycle_sync_bit,
    output reg         interpolation_enable,
    output reg         interrupt_request_n
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers; stage one feeds stage two only
reg [1:0] sclk_s, mosi_s, ss_s;
reg       sclk_d, ss_d;
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        sclk_s <= 2'h0;
        mosi_s <= 2'h0;
        ss_s   <= 2'h3;
        sclk_d <= 1'b0;
        ss_d   <= 1'b1;
    end else begin
        sclk_s <= {sclk_s[0], sclk};
        mosi_s <= {mosi_s[0], mosi};
        ss_s   <= {ss_s[0], slave_select_n};
        sclk_d <= sclk_s[1];
        ss_d   <= ss_s[1];
    end
end
wire sclk_rise = sclk_s[1] & ~sclk_d;
wire sclk_fall = ~sclk_s[1] & sclk_d;
wire ss_fall   = ~ss_s[1] & ss_d;
wire ss_rise   = ss_s[1] & ~ss_d;
wire active    = ~ss_s[1];

////////////////////////////////////////////////////////////////////////////////
// refresh of the reported angle only
// the integer quotient is kept at 32 bits and cut to the counter width on purpose
wire [31:0]           slow_cyc_full = `SLOW_REFRESH_CYC;
wire [`REFRESH_W-1:0] slow_cnt_max  = slow_cyc_full[`REFRESH_W-1:0];
reg  [`REFRESH_W-1:0] refresh_cnt;
// at 20 MHz the fast 20 ns rate is faster than the clock, so every edge refreshes
wire refresh_now = ~quad_outputs_enabled | (refresh_cnt == slow_cnt_max - 1'b1);
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
        refresh_cnt <= {`REFRESH_W{1'b0}};
    else if (refresh_now)
        refresh_cnt <= {`REFRESH_W{1'b0}};
    else
        refresh_cnt <= refresh_cnt + 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// frame shifter
reg [`BIT_CNT_W-1:0] bit_cnt;
reg [31:0]           rx_shift;
reg [31:0]           tx_shift;
reg                  frame_done;
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        bit_cnt    <= {`BIT_CNT_W{1'b0}};
        rx_shift   <= 32'h0;
        frame_done <= 1'b0;
    end else if (ss_fall) begin
        bit_cnt    <= {`BIT_CNT_W{1'b0}};
        frame_done <= 1'b0;
    end else if (active && sclk_rise && !frame_done) begin
        rx_shift <= {rx_shift[30:0], mosi_s[1]};
        bit_cnt  <= bit_cnt + 1'b1;
        if (bit_cnt == `FRAME_BITS - 1'b1)
            frame_done <= 1'b1;
    end
end

// a command is valid only when all 32 bits arrived and the start bit is set
wire cmd_valid = ss_rise & frame_done & rx_shift[`START_BIT] &
                 (rx_shift[`RSV_HI:`RSV_LO] == 3'h0);
wire [1:0] cmd_wm = rx_shift[`WM_HI:`WM_LO];
wire [1:0] cmd_rm = rx_shift[`RM_HI:`RM_LO];

////////////////////////////////////////////////////////////////////////////////
// cycle counter, status flags and command execution
reg [13:0] cycle_counter;
reg [9:0]  angle;
reg [13:0] pending_count;
reg        pending_sync;
reg        pending_load;
reg [1:0]  last_rm;
reg        rollover_event_flag, rollover_lost_flag;
reg        capture_event_flag, capture_lost_flag;
reg [13:0] cap_counter;
reg [9:0]  cap_angle;
wire       fatal_fault_flag = |fatal_fault_reg;
wire [13:0] count_next = counter_dir_down ? cycle_counter - 1'b1 : cycle_counter + 1'b1;
wire [7:0]  status_byte = {2'h0, fatal_fault_flag, ~interrupt_request_n,
                           capture_lost_flag, capture_event_flag,
                           rollover_lost_flag, rollover_event_flag};
// a crossing up goes to a multiple, a crossing down leaves one
wire roll_cross = counter_step &&
    (counter_dir_down ? (cycle_counter[`ROLL_BIT:0] == 12'h000)
                      : (count_next[`ROLL_BIT:0] == 12'h000));
wire read_pos = ss_fall & (last_rm == `RM_POSITION);
wire read_cap = ss_fall & (last_rm == `RM_CAPTURE);

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        cycle_counter        <= 14'h0;
        angle                <= 10'h0;
        pending_count        <= 14'h0;
        pending_sync         <= 1'b0;
        pending_load         <= 1'b0;
        last_rm              <= `RM_POSITION;
        rollover_event_flag  <= 1'b0;
        rollover_lost_flag   <= 1'b0;
        capture_event_flag   <= 1'b0;
        capture_lost_flag    <= 1'b0;
        cap_counter          <= 14'h0;
        cap_angle            <= 10'h0;
        reg_addr             <= 16'h0;
        reg_wdata            <= 8'h0;
        reg_write            <= 1'b0;
        cycle_sync_bit       <= 1'b0;
        interpolation_enable <= 1'b1;
    end else begin
        reg_write <= 1'b0;
        if (fatal_fault_flag)
            interpolation_enable <= 1'b0;
        else if (restart_cmd)
            interpolation_enable <= 1'b1;
        if (refresh_now)
            angle <= angle_in;
        if (counter_step && interpolation_enable)
            cycle_counter <= count_next;
        // reading clears, but an event in the same cycle wins
        if (read_pos) begin
            rollover_event_flag <= 1'b0;
            rollover_lost_flag  <= 1'b0;
        end
        if (roll_cross && interpolation_enable) begin
            rollover_event_flag <= 1'b1;
            if (rollover_event_flag && !read_pos)
                rollover_lost_flag <= 1'b1;
        end
        if (read_cap) begin
            capture_event_flag <= 1'b0;
            capture_lost_flag  <= 1'b0;
        end
        if (capture_pulse) begin
            capture_event_flag <= 1'b1;
            cap_counter        <= capture_counter_in;
            cap_angle          <= capture_angle_in;
            if (capture_event_flag && !read_cap)
                capture_lost_flag <= 1'b1;
        end
        if (ss_fall && pending_load) begin
            cycle_counter  <= pending_count;
            cycle_sync_bit <= pending_sync;
            pending_load   <= 1'b0;
        end
        if (cmd_valid) begin
            last_rm <= cmd_rm;
            case (cmd_wm)
                `WM_NULL: begin
                end
                `WM_COUNTER: begin
                    cycle_counter  <= rx_shift[`CNT_HI:`CNT_LO];
                    cycle_sync_bit <= rx_shift[0];
                end
                `WM_ATOMIC: begin
                    pending_count <= rx_shift[`CNT_HI:`CNT_LO];
                    pending_sync  <= rx_shift[0];
                    pending_load  <= 1'b1;
                end
                `WM_REGISTER: begin
                    reg_addr  <= rx_shift[`ADDR_HI:`ADDR_LO];
                    reg_wdata <= rx_shift[`DATA_HI:`DATA_LO];
                    reg_write <= 1'b1;
                end
                default: begin
                end
            endcase
            if (cmd_rm == `RM_REGVAL && cmd_wm != `WM_REGISTER)
                reg_addr <= rx_shift[`ADDR_HI:`ADDR_LO];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// response snapshot and shift out
reg [31:0] response;
always @* begin
    case (last_rm)
        `RM_POSITION: response = {status_byte, cycle_counter, angle};
        `RM_CAPTURE:  response = {status_byte, cap_counter, cap_angle};
        `RM_ADC:      response = {4'h0, sine_sample, cosine_sample, index_sample};
        `RM_REGVAL:   response = {reg_read_data, cycle_counter, angle};
        default:      response = 32'h0;
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tx_shift            <= 32'h0;
        miso                <= 1'b0;
        miso_oe             <= 1'b0;
        interrupt_request_n <= 1'b1;
    end else begin
        interrupt_request_n <= ~(irq_request_in | fatal_fault_flag |
                                 (capture_irq_enable & capture_event_flag) |
                                 (rollover_irq_enable & rollover_event_flag));
        miso_oe <= active;
        if (ss_fall) begin
            // the previous command's data leave in this frame
            tx_shift <= {response[30:0], 1'b0};
            miso     <= response[31];
        end else if (active && sclk_fall && !frame_done) begin
            miso     <= tx_shift[31];
            tx_shift <= {tx_shift[30:0], 1'b0};
        end
    end
end

endmodule

// [spi_position_command_port_defines.vh]
// constants for the spi position command port
// assumes a 20 MHz system clock and an spi link in mode 0
`ifndef SPI_POSITION_COMMAND_PORT_DEFINES_VH
`define SPI_POSITION_COMMAND_PORT_DEFINES_VH
`define FRAME_BITS        6'd32
`define BIT_CNT_W         6
`define START_BIT         31
`define RM_HI             30
`define RM_LO             29
`define WM_HI             28
`define WM_LO             27
`define RSV_HI            26
`define RSV_LO            24
`define WM_NULL           2'h0
`define WM_COUNTER        2'h1
`define WM_ATOMIC         2'h2
`define WM_REGISTER       2'h3
`define RM_POSITION       2'h0
`define RM_CAPTURE        2'h1
`define RM_ADC            2'h2
`define RM_REGVAL         2'h3
`define CNT_HI            14
`define CNT_LO            1
`define ADDR_HI           23
`define ADDR_LO           8
`define DATA_HI           7
`define DATA_LO           0
`define ROLL_BIT          11
`define CLK_PERIOD_NS     50
`define SLOW_REFRESH_NS   320
`define FAST_REFRESH_NS   20
`define SLOW_REFRESH_CYC  ((`SLOW_REFRESH_NS) / (`CLK_PERIOD_NS))
`define REFRESH_W         3
`endif

// [spi_position_command_port_monitor.sv]
// checker of the spi position command port
// assumes it is bound to the port module and sees only its ports
`timescale 1ns/100ps
module spi_position_command_port_monitor (
    input wire       sys_clk,
    input wire       rst_n,
    input wire       sclk,
    input wire       slave_select_n,
    input wire       miso,
    input wire       miso_oe,
    input wire [7:0] fatal_fault_reg,
    input wire       irq_request_in,
    input wire       restart_cmd,
    input wire       reg_write,
    input wire       interpolation_enable,
    input wire       interrupt_request_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    oe_on_a: assert property ($fell(slave_select_n) |-> ##[2:5] miso_oe)
        else $error("miso enable late");
    oe_off_a: assert property ($rose(slave_select_n) |-> ##[2:5] !miso_oe)
        else $error("miso enable stuck");
    // sclk is synced, so miso may only move a few clocks after a fall
    miso_hold_a: assert property ((!slave_select_n && sclk) [*4] |-> $stable(miso))
        else $error("miso moved while sclk high");
    wr_pulse_a: assert property (reg_write |=> !reg_write)
        else $error("register write too long");
    wr_framed_a: assert property ($rose(reg_write) |-> slave_select_n)
        else $error("register write inside frame");
    irq_fault_a: assert property (fatal_fault_reg != 8'h00 |-> ##[1:2] !interrupt_request_n)
        else $error("no interrupt on fault");
    irq_req_a: assert property (irq_request_in |-> ##[1:2] !interrupt_request_n)
        else $error("no interrupt on request");
    fault_halt_a: assert property (fatal_fault_reg != 8'h00 |=> !interpolation_enable)
        else $error("interpolation not halted");
    halt_hold_a: assert property (!interpolation_enable && !restart_cmd && !$past(restart_cmd)
        |=> !interpolation_enable) else $error("interpolation resumed alone");
endmodule
bind spi_position_command_port spi_position_command_port_monitor u_mon (.sys_clk, .rst_n, .sclk,
    .slave_select_n, .miso, .miso_oe, .fatal_fault_reg, .irq_request_in, .restart_cmd,
    .reg_write, .interpolation_enable, .interrupt_request_n);

// [spi_host_model.sv]
// spi host master model, mode 0, 400 ns link clock
// assumes the caller leaves frames apart; phase is offset from sys_clk
`timescale 1ns/100ps
module spi_host_model (
    output logic sclk = 1'b0,
    output logic mosi = 1'b0,
    output logic slave_select_n = 1'b1,
    input  wire  miso
);
    task xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        #13 slave_select_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi = cmd[i];
            #200 sclk = 1'b1;
            rsp[i] = miso;
            #200 sclk = 1'b0;
        end
        #200 slave_select_n = 1'b1;
        // a released line must not look like it still holds the last bit
        mosi = ~mosi;
        // a whole frame takes 272 sys_clk periods, so the caller resumes on a falling edge
        #587;
    endtask
endmodule

// [tb_spi_position_command_port.sv]
// self-checking bench of the spi position command port
// assumes the host model as spi master and a 20 MHz sys_clk
`timescale 1ns/100ps
module tb_spi_position_command_port;
    logic        sys_clk = 1'b0, rst_n = 1'b0, quad_outputs_enabled = 1'b0, counter_step = 1'b0;
    logic        counter_dir_down = 1'b0, capture_pulse = 1'b0, irq_request_in = 1'b0;
    logic        capture_irq_enable = 1'b0, rollover_irq_enable = 1'b0, restart_cmd = 1'b0;
    logic [9:0]  angle_in = 10'h0, capture_angle_in = 10'h0, sine_sample = 10'h0;
    logic [9:0]  cosine_sample = 10'h0;
    logic [13:0] capture_counter_in = 14'h0, cnt = 14'h0, v;
    logic [7:0]  index_sample = 8'h0, fatal_fault_reg = 8'h0, reg_read_data = 8'h0, reg_wdata;
    logic [15:0] reg_addr;
    logic [31:0] lfsr = 32'h6bdc5f0c, rsp;
    logic [23:0] wr_last;
    logic [1:0]  prm = 2'h0;
    wire         sclk, mosi, slave_select_n, miso, miso_oe, reg_write, cycle_sync_bit;
    wire         interpolation_enable, interrupt_request_n;
    int          errors = 0, cmp_count = 0, wr_seen = 0;
    bit          skip = 1'b0;
    spi_position_command_port u_spi_position_command_port (.sys_clk, .rst_n, .sclk, .mosi,
        .slave_select_n, .miso, .miso_oe, .angle_in, .quad_outputs_enabled, .counter_step,
        .counter_dir_down, .capture_pulse, .capture_counter_in, .capture_angle_in, .sine_sample,
        .cosine_sample, .index_sample, .fatal_fault_reg, .irq_request_in, .capture_irq_enable,
        .rollover_irq_enable, .restart_cmd, .reg_read_data, .reg_addr, .reg_wdata, .reg_write,
        .cycle_sync_bit, .interpolation_enable, .interrupt_request_n);
    spi_host_model u_spi_host_model (.sclk, .mosi, .slave_select_n, .miso);
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (reg_write) begin
        wr_seen <= wr_seen + 1;
        wr_last <= {reg_addr, reg_wdata};
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [31:0] exp_rsp(input logic [1:0] rm, input logic [7:0] st);
        case (rm)
            2'h0: return {st, cnt, angle_in};
            2'h1: return {st, capture_counter_in, capture_angle_in};
            2'h2: return {4'h0, sine_sample, cosine_sample, index_sample};
            default: return {reg_read_data, cnt, angle_in};
        endcase
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // st is the status expected in this response, which answers the previous command
    task frame(input logic [1:0] rm, input logic [1:0] wm, input logic [23:0] d,
               input logic [7:0] st);
        u_spi_host_model.xfer({1'b1, rm, wm, 3'h0, d}, rsp);
        if (!skip) chk(rsp, exp_rsp(prm, st));
        prm = rm;
    endtask
    task step(input logic dn);
        @(negedge sys_clk) counter_step = 1'b1;
        counter_dir_down = dn;
        @(negedge sys_clk) counter_step = 1'b0;
        cnt = dn ? cnt - 14'h1 : cnt + 14'h1;
    endtask
    task end_of_test();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #3_000_000 errors++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        skip = 1'b1;
        frame(2'h0, 2'h1, {9'h0, 14'h0fff, 1'b1}, 8'h0);
        skip = 1'b0;
        cnt = 14'h0fff;
        chk({31'h0, cycle_sync_bit}, 32'h1);
        rollover_irq_enable = 1'b1;
        step(1'b0);
        step(1'b1);
        chk({31'h0, interrupt_request_n}, 32'h0);
        frame(2'h0, 2'h0, 24'hffffff, 8'h13);
        rollover_irq_enable = 1'b0;
        frame(2'h1, 2'h0, 24'h0, 8'h00);
        capture_counter_in = rnd();
        capture_angle_in = rnd();
        repeat (2) @(negedge sys_clk) capture_pulse = ~capture_pulse;
        repeat (2) @(negedge sys_clk) capture_pulse = ~capture_pulse;
        frame(2'h2, 2'h0, 24'h0, 8'h0c);
        frame(2'h0, 2'h0, 24'h0, 8'h00);
        frame(2'h1, 2'h0, 24'h0, 8'h00);
        {sine_sample, cosine_sample, index_sample} = rnd();
        frame(2'h3, 2'h3, 24'h4000a5, 8'h00);
        chk(wr_seen, 32'h1);
        chk({8'h0, wr_last}, {8'h0, 24'h4000a5});
        reg_read_data = rnd();
        frame(2'h0, 2'h0, 24'h0, 8'h00);
        // kept well below 0x2000 so the random steps later cross no rollover boundary
        v = 14'h1800 | (rnd() & 32'h3ff);
        frame(2'h0, 2'h2, {9'h0, v, 1'b0}, 8'h00);
        skip = 1'b1;
        frame(2'h0, 2'h0, 24'h0, 8'h00);
        cnt = v;
        u_spi_host_model.xfer({8'h08, 24'h000002}, rsp);
        frame(2'h0, 2'h0, 24'h0, 8'h00);
        skip = 1'b0;
        frame(2'h0, 2'h0, 24'h0, 8'h00);
        @(negedge sys_clk) fatal_fault_reg = rnd() | 32'h1;
        irq_request_in = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({31'h0, interpolation_enable}, 32'h0);
        frame(2'h0, 2'h0, 24'h0, 8'h30);
        fatal_fault_reg = 8'h00;
        irq_request_in = 1'b0;
        @(negedge sys_clk) restart_cmd = 1'b1;
        @(negedge sys_clk) restart_cmd = 1'b0;
        chk({31'h0, interpolation_enable}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            {angle_in, quad_outputs_enabled} = rnd();
            step(rnd() & 1);
            repeat (8) @(negedge sys_clk);
            frame(rnd(), 2'h0, rnd(), 8'h00);
        end
        end_of_test();
    end
endmodule
